/* File: rtl/pcm_audio_serial_input.sv */
// Serial PCM audio input port with APB control and a sample FIFO.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`default_nettype none
module pcm_audio_serial_input #(
   parameter int FIFO_DEPTH = 4
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic master_clock_in,
   output logic master_clock_out,
   input wire logic bit_clock_pin_i,
   output logic bit_clock_pin_o,
   output logic bit_clock_pin_oe_n,
   input wire logic channel_select_clock_pin_i,
   output logic channel_select_clock_pin_o,
   output logic channel_select_clock_pin_oe_n,
   input wire logic serial_sample_in,
   output logic sample_valid,
   input wire logic sample_ready,
   output logic [pcm_in_pkg::SAMPLE_W-1:0] sample_data,
   output logic sample_right
);
   localparam int LW = $clog2(FIFO_DEPTH) + 1;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] mclk_s, bck_s, lr_s, din_s;
   logic mclk_prev;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         mclk_s <= 2'h0;
         bck_s <= 2'h0;
         lr_s <= 2'h0;
         din_s <= 2'h0;
         mclk_prev <= 1'b0;
      end else begin
         mclk_s <= {mclk_s[0], master_clock_in};
         bck_s <= {bck_s[0], bit_clock_pin_i};
         lr_s <= {lr_s[0], channel_select_clock_pin_i};
         din_s <= {din_s[0], serial_sample_in};
         mclk_prev <= mclk_s[1];
      end
   end
   logic mclk_rise;
   assign mclk_rise = mclk_s[1] && !mclk_prev;

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   logic [7:0] ctrl, next_ctrl;
   logic enable, master, linear, ratio384;
   pcm_in_pkg::framing_type framing;
   logic [4:0] wl;
   logic cfg_err;
   assign enable = ctrl[pcm_in_pkg::CTRL_ENABLE_BIT];
   assign master = ctrl[pcm_in_pkg::CTRL_MASTER_BIT];
   assign linear = ctrl[pcm_in_pkg::CTRL_LINEAR_BIT];
   assign ratio384 = ctrl[pcm_in_pkg::CTRL_RATIO_BIT];
   assign framing = pcm_in_pkg::framing_type'(ctrl[pcm_in_pkg::CTRL_FRAMING_LSB +: 2]);

   always_comb begin
      case (ctrl[pcm_in_pkg::CTRL_WL_LSB +: 2])
         2'h0: wl = pcm_in_pkg::WL_16;
         2'h1: wl = pcm_in_pkg::WL_18;
         2'h2: wl = pcm_in_pkg::WL_20;
         default: wl = pcm_in_pkg::WL_24;
      endcase
      if (linear) begin
         wl = pcm_in_pkg::WL_16;
      end
   end
   // Linear PCM with a longer word, or the spare framing code, is flagged.
   assign cfg_err = (linear && ctrl[pcm_in_pkg::CTRL_WL_LSB +: 2] != 2'h0) ||
                    (framing == pcm_in_pkg::FRAMING_SPARE);

   // ----------------------------------------------------------------
   // Master clock generation
   // ----------------------------------------------------------------
   logic [1:0] mdiv, next_mdiv;
   logic [5:0] gen_bits, next_gen_bits;
   logic bck_gen, next_bck_gen, lr_gen, next_lr_gen, mclk_out, next_mclk_out;
   logic [1:0] half_bit;
   assign half_bit = ratio384 ? pcm_in_pkg::HALF_BIT_384FS : pcm_in_pkg::HALF_BIT_256FS;

   always_comb begin
      next_mdiv = mdiv;
      next_bck_gen = bck_gen;
      next_lr_gen = lr_gen;
      next_gen_bits = gen_bits;
      next_mclk_out = enable && master && mclk_s[1];
      if (!(enable && master)) begin
         next_mdiv = 2'h0;
         next_bck_gen = 1'b0;
         next_lr_gen = 1'b0;
         next_gen_bits = 6'h0;
      end else if (mclk_rise) begin
         if (mdiv == half_bit - 2'h1) begin
            next_mdiv = 2'h0;
            next_bck_gen = !bck_gen;
            if (bck_gen) begin
               // Channel clock changes on a falling bit clock edge.
               if (gen_bits == pcm_in_pkg::BITS_PER_CHANNEL - 6'h1) begin
                  next_gen_bits = 6'h0;
                  next_lr_gen = !lr_gen;
               end else begin
                  next_gen_bits = gen_bits + 6'h1;
               end
            end
         end else begin
            next_mdiv = mdiv + 2'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         mdiv <= 2'h0;
         bck_gen <= 1'b0;
         lr_gen <= 1'b0;
         gen_bits <= 6'h0;
         mclk_out <= 1'b0;
      end else begin
         mdiv <= next_mdiv;
         bck_gen <= next_bck_gen;
         lr_gen <= next_lr_gen;
         gen_bits <= next_gen_bits;
         mclk_out <= next_mclk_out;
      end
   end

   assign master_clock_out = mclk_out;
   assign bit_clock_pin_o = bck_gen;
   assign channel_select_clock_pin_o = lr_gen;
   assign bit_clock_pin_oe_n = !(enable && master);
   assign channel_select_clock_pin_oe_n = !(enable && master);

   // ----------------------------------------------------------------
   // Serial receiver
   // ----------------------------------------------------------------
   logic bck_now, lr_now, bck_prev, next_bck_prev, bit_rise;
   logic lr_last, next_lr_last, lr_changed;
   logic [31:0] sreg, next_sreg;
   logic [5:0] bit_cnt, next_bit_cnt;
   logic capture, cap_right;
   logic [pcm_in_pkg::SAMPLE_W-1:0] cap_data;
   logic [5:0] target;
   logic fifo_in_ready;

   assign bck_now = master ? bck_gen : bck_s[1];
   assign lr_now = master ? lr_gen : lr_s[1];
   assign bit_rise = enable && bck_now && !bck_prev;
   assign lr_changed = lr_now != lr_last;
   assign target = {1'b0, wl} + ((framing == pcm_in_pkg::FRAMING_I2S) ? 6'h1 : 6'h0);

   always_comb begin
      next_bck_prev = bck_now;
      next_lr_last = lr_last;
      next_sreg = sreg;
      // A disabled port forgets its bit position, so a stale count cannot complete a word later.
      next_bit_cnt = enable ? bit_cnt : 6'h0;
      capture = 1'b0;
      cap_right = 1'b0;
      cap_data = '0;
      if (bit_rise) begin
         next_lr_last = lr_now;
         next_sreg = {sreg[30:0], din_s[1]};
         next_bit_cnt = lr_changed ? 6'h1 : ((bit_cnt == 6'h3f) ? bit_cnt : bit_cnt + 6'h1);
         case (framing)
            pcm_in_pkg::FRAMING_I2S, pcm_in_pkg::FRAMING_LEFT: begin
               // The word is complete once its last bit after the delay is in.
               capture = (next_bit_cnt == target);
               cap_data = next_sreg[23:0] << (5'h18 - wl);
               // In I2S a low channel clock marks left, else a high one does.
               cap_right = (framing == pcm_in_pkg::FRAMING_I2S) ? lr_now : !lr_now;
            end
            pcm_in_pkg::FRAMING_RIGHT: begin
               // The word ends just before the channel clock changes.
               capture = lr_changed && bit_cnt >= {1'b0, wl};
               cap_data = sreg[23:0] << (5'h18 - wl);
               cap_right = lr_now;
            end
            default: begin
               capture = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         bck_prev <= 1'b0;
         lr_last <= 1'b0;
         sreg <= 32'h0;
         bit_cnt <= 6'h0;
      end else begin
         bck_prev <= next_bck_prev;
         lr_last <= next_lr_last;
         sreg <= next_sreg;
         bit_cnt <= next_bit_cnt;
      end
   end

   logic [LW-1:0] fifo_level;
   sample_fifo #(
      .WIDTH(pcm_in_pkg::SAMPLE_W + 1),
      .DEPTH(FIFO_DEPTH)
   ) sample_fifo_i (
      .clk(clk),
      .reset_n(reset_n),
      .in_valid(capture),
      .in_ready(fifo_in_ready),
      .in_data({cap_right, cap_data}),
      .out_valid(sample_valid),
      .out_ready(sample_ready),
      .out_data({sample_right, sample_data}),
      .level(fifo_level)
   );

   // ----------------------------------------------------------------
   // APB slave and status
   // ----------------------------------------------------------------
   logic overrun, next_overrun;
   logic [31:0] count, next_count, next_prdata;
   logic next_pslverr, setup, wr_access, mapped;
   assign setup = psel && !penable;
   assign wr_access = psel && penable && pwrite;
   assign pready = 1'b1;
   assign mapped = paddr == pcm_in_pkg::CTRL_OFFSET || paddr == pcm_in_pkg::STATUS_OFFSET ||
                   paddr == pcm_in_pkg::COUNT_OFFSET;

   always_comb begin
      next_ctrl = ctrl;
      next_overrun = overrun;
      next_count = count + ((capture && fifo_in_ready) ? 32'h1 : 32'h0);
      next_prdata = prdata;
      next_pslverr = pslverr;
      if (wr_access && pstrb[0] && paddr == pcm_in_pkg::CTRL_OFFSET) begin
         next_ctrl = pwdata[7:0];
      end
      if (wr_access && pstrb[0] && paddr == pcm_in_pkg::STATUS_OFFSET &&
          pwdata[pcm_in_pkg::STATUS_OVERRUN_BIT]) begin
         next_overrun = 1'b0;
      end
      // A lost word in the same cycle as the clear keeps the flag set.
      if (capture && !fifo_in_ready) begin
         next_overrun = 1'b1;
      end
      if (setup) begin
         next_pslverr = !mapped;
         next_prdata = 32'h0;
         case (paddr)
            pcm_in_pkg::CTRL_OFFSET: next_prdata[7:0] = ctrl;
            pcm_in_pkg::STATUS_OFFSET: begin
               next_prdata[pcm_in_pkg::STATUS_OVERRUN_BIT] = overrun;
               next_prdata[pcm_in_pkg::STATUS_CFG_ERR_BIT] = cfg_err;
               next_prdata[pcm_in_pkg::STATUS_LEVEL_LSB +: LW] = fifo_level;
               next_prdata[pcm_in_pkg::STATUS_LR_BIT] = lr_last;
            end
            pcm_in_pkg::COUNT_OFFSET: next_prdata = count;
            default: next_prdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrl <= pcm_in_pkg::CTRL_RESET;
         overrun <= 1'b0;
         count <= 32'h0;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         overrun <= next_overrun;
         count <= next_count;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_pin_direction: assert property (bit_clock_pin_oe_n == channel_select_clock_pin_oe_n &&
      bit_clock_pin_oe_n == !(enable && master)) else $error("pin direction wrong");
   a_slave_no_drive: assert property (!master |-> bit_clock_pin_oe_n ##1 !master_clock_out)
      else $error("slave mode drives clocks");
   a_bck_on_mclk: assert property ($changed(bck_gen) && $past(enable && master) |-> $past(mclk_rise))
      else $error("bit clock moved without master clock edge");
   a_lr_on_fall: assert property ($changed(lr_gen) && $past(enable && master) |-> $fell(bck_gen))
      else $error("channel clock moved off falling bit clock");
   a_linear_sixteen: assert property (linear |-> wl == pcm_in_pkg::WL_16)
      else $error("linear PCM word not 16 bits");
   a_capture_edge: assert property (capture |-> enable && $rose(bck_prev) == 1'b0 && bit_rise)
      else $error("capture outside bit clock edge");
   a_i2s_channel: assert property (capture && framing == pcm_in_pkg::FRAMING_I2S |-> cap_right == lr_now)
      else $error("I2S channel misassigned");
   a_overrun_sticky: assert property (capture && !fifo_in_ready |=> overrun [*2])
      else $error("overrun not held");
   a_ctrl_write: assert property (wr_access && pstrb[0] && paddr == pcm_in_pkg::CTRL_OFFSET |=>
      ctrl == $past(pwdata[7:0])) else $error("control write lost");
   a_unmapped_err: assert property (setup && !mapped |=> pslverr) else $error("unmapped not refused");

   c_i2s: cover property (capture && framing == pcm_in_pkg::FRAMING_I2S);
   c_left: cover property (capture && framing == pcm_in_pkg::FRAMING_LEFT);
   c_right: cover property (capture && framing == pcm_in_pkg::FRAMING_RIGHT);
   c_overrun: cover property (capture && !fifo_in_ready);
endmodule : pcm_audio_serial_input
`default_nettype wire

/* File: common/pcm_in_pkg.sv */
// Shared constants and types for the serial PCM audio input port.
`default_nettype none
package pcm_in_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] COUNT_OFFSET = 8'h08;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_MASTER_BIT = 1;
   localparam int CTRL_FRAMING_LSB = 2;
   localparam int CTRL_WL_LSB = 4;
   localparam int CTRL_LINEAR_BIT = 6;
   localparam int CTRL_RATIO_BIT = 7;
   localparam int STATUS_OVERRUN_BIT = 0;
   localparam int STATUS_CFG_ERR_BIT = 1;
   localparam int STATUS_LEVEL_LSB = 2;
   localparam int STATUS_LR_BIT = 5;
   // ----------------------------------------------------------------
   // Framing, word length and clock ratios
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      FRAMING_I2S = 2'h0,
      FRAMING_LEFT = 2'h1,
      FRAMING_RIGHT = 2'h2,
      FRAMING_SPARE = 2'h3
   } framing_type;
   localparam int SAMPLE_RATE_HZ = 48000;
   localparam int SAMPLE_W = 24;
   localparam logic [4:0] WL_16 = 5'h10;
   localparam logic [4:0] WL_18 = 5'h12;
   localparam logic [4:0] WL_20 = 5'h14;
   localparam logic [4:0] WL_24 = 5'h18;
   localparam logic [5:0] BITS_PER_CHANNEL = 6'h20;
   localparam logic [1:0] HALF_BIT_256FS = 2'h2;
   localparam logic [1:0] HALF_BIT_384FS = 2'h3;
endpackage : pcm_in_pkg
`default_nettype wire

/* File: rtl/sample_fifo.sv */
// Small synchronous FIFO carrying received samples to the sample output.
`default_nettype none
module sample_fifo #(
   parameter int WIDTH = 25,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [PW:0] next_level;
   logic push, pop;

   assign in_ready = (level != (PW+1)'(DEPTH));
   assign out_valid = (level != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      if (push) begin
         next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      next_level = level + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         level <= next_level;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule : sample_fifo
`default_nettype wire

/* File: verif/adc_model.sv */
// Behavioural external audio converter feeding the serial sample line.
`default_nettype none
module adc_model (
   input wire logic bit_clock_wire,
   input wire logic channel_clock_wire,
   input wire pcm_in_pkg::framing_type framing,
   input wire logic [4:0] word_len,
   input wire logic [23:0] left_word,
   input wire logic [23:0] right_word,
   output logic bit_clock_drive,
   output logic channel_clock_drive,
   output logic serial_out
);
   // The converter takes no master clock back from the port.
   timeunit 1ns;
   timeprecision 100ps;
   int pos = 0;
   int k;
   logic lr_prev = 1'b0;
   logic [23:0] w;
   initial begin
      bit_clock_drive = 1'b1;
      channel_clock_drive = 1'b0;
      serial_out = 1'b0;
   end
   // Data changes just after each falling bit clock; bits outside the word keep toggling.
   always @(negedge bit_clock_wire) begin
      #1;
      pos = (channel_clock_wire !== lr_prev) ? 0 : pos + 1;
      lr_prev = channel_clock_wire;
      w = ((framing == pcm_in_pkg::FRAMING_I2S) == (lr_prev == 1'b0)) ? left_word : right_word;
      k = (framing == pcm_in_pkg::FRAMING_I2S) ? pos - 1 :
          (framing == pcm_in_pkg::FRAMING_LEFT) ? pos : pos - (32 - int'(word_len));
      if (k >= 0 && k < int'(word_len)) begin
         serial_out = w[23 - k];
      end else begin
         serial_out = ~serial_out;
      end
   end
   // One lead-in bit shows the old channel level, then whole halves and a short tail; clocks stand still after.
   task automatic run_halves(input int halves, input logic first_level);
      channel_clock_drive = ~first_level;
      lr_prev = ~first_level;
      #41;
      for (int h = -1; h <= halves; h++) begin
         for (int b = 0; b < ((h < 0) ? 1 : (h == halves) ? 2 : 32); b++) begin
            bit_clock_drive = 1'b0;
            if (b == 0 && h >= 0) begin
               channel_clock_drive = ~channel_clock_drive;
            end
            #16;
            bit_clock_drive = 1'b1;
            #16;
         end
      end
   endtask : run_halves
endmodule : adc_model
`default_nettype wire

/* File: verif/pcm_audio_serial_input_test.sv */
// Self-checking bench for the serial PCM audio input port.
`default_nettype none
module pcm_audio_serial_input_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready, pslverr, master_clock_out, sample_valid, sample_right, serial_sample_in;
   logic master_clock_in = 1'b0;
   logic sample_ready = 1'b1;
   logic bit_clock_pin_o, bit_clock_pin_oe_n, channel_select_clock_pin_o, channel_select_clock_pin_oe_n;
   logic bclk_drv, lr_drv;
   wire logic bit_clock_pin_i;
   wire logic channel_select_clock_pin_i;
   logic [23:0] sample_data;
   pcm_in_pkg::framing_type framing = pcm_in_pkg::FRAMING_I2S;
   logic [4:0] word_len = 5'h10;
   logic [23:0] left_word = 24'h9e3b71;
   logic [23:0] right_word = 24'h5a2d8e;
   logic [4:0] wl_tab [4] = '{pcm_in_pkg::WL_16, pcm_in_pkg::WL_18, pcm_in_pkg::WL_20, pcm_in_pkg::WL_24};
   logic [23:0] qd[$];
   logic qr[$];
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   assign bit_clock_pin_i = bit_clock_pin_oe_n ? bclk_drv : bit_clock_pin_o;
   assign channel_select_clock_pin_i = channel_select_clock_pin_oe_n ? lr_drv : channel_select_clock_pin_o;
   pcm_audio_serial_input #(.FIFO_DEPTH(4)) pcm_audio_serial_input_i (
      .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .master_clock_in, .master_clock_out, .bit_clock_pin_i, .bit_clock_pin_o, .bit_clock_pin_oe_n,
      .channel_select_clock_pin_i, .channel_select_clock_pin_o, .channel_select_clock_pin_oe_n,
      .serial_sample_in, .sample_valid, .sample_ready, .sample_data, .sample_right);
   adc_model adc_model_i (.bit_clock_wire(bit_clock_pin_i), .channel_clock_wire(channel_select_clock_pin_i),
      .framing(framing), .word_len(word_len), .left_word(left_word), .right_word(right_word),
      .bit_clock_drive(bclk_drv), .channel_clock_drive(lr_drv), .serial_out(serial_sample_in));
   always #2 clk = ~clk;
   initial begin
      #1;
      forever #16 master_clock_in = ~master_clock_in;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (sample_valid === 1'b1 && sample_ready === 1'b1) begin
         qd.push_back(sample_data);
         qr.push_back(sample_right);
      end
      if (cycles == 80000) begin
         fail_count = fail_count + 1;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic [31:0] ctrl(input logic en, input logic ms, input logic [1:0] f,
                                        input logic [1:0] wc, input logic lin, input logic rt);
      return {24'h0, rt, lin, wc, f, ms, en};
   endfunction : ctrl
   function automatic logic pick(input int sel);
      return (sel == 0) ? master_clock_out : (sel == 1) ? bit_clock_pin_o : channel_select_clock_pin_o;
   endfunction : pick
   // Counts clock cycles between two successive changes of the selected output clock.
   task automatic gap(input int sel, output int n);
      logic v;
      for (int i = 0; i < 2; i++) begin
         v = pick(sel);
         n = 0;
         while (pick(sel) === v && n < 4000) begin
            @(posedge clk);
            n++;
         end
      end
   endtask : gap
   task automatic check_pair(input int wl);
      logic [23:0] m;
      m = 24'hffffff << (24 - wl);
      chk("sample count", 1, qd.size() >= 2);
      if (qd.size() >= 2) begin
         chk("channel tags", 1, qr[$] ^ qr[$-1]);
         chk("sample data", (qr[$] ? right_word : left_word) & m, qd[$]);
         chk("sample data", (qr[$-1] ? right_word : left_word) & m, qd[$-1]);
      end
   endtask : check_pair
   task automatic reg_case();
      logic [31:0] r;
      logic e;
      apb(1'b0, pcm_in_pkg::CTRL_OFFSET, 32'h0, 4'h0, r, e);
      chk("control reset", 32'h0, r);
      apb(1'b1, pcm_in_pkg::CTRL_OFFSET, 32'hfffffffe, 4'hf, r, e);
      apb(1'b1, pcm_in_pkg::CTRL_OFFSET, 32'h0, 4'he, r, e);
      apb(1'b0, pcm_in_pkg::CTRL_OFFSET, 32'h0, 4'h0, r, e);
      chk("control readback", 32'hfe, r);
      chk("ready held", 1, pready);
      apb(1'b0, pcm_in_pkg::STATUS_OFFSET, 32'h0, 4'h0, r, e);
      chk("framing error", 1, r[pcm_in_pkg::STATUS_CFG_ERR_BIT]);
      chk("bit clock released", 1, bit_clock_pin_oe_n);
      apb(1'b1, pcm_in_pkg::COUNT_OFFSET, 32'h5a, 4'hf, r, e);
      apb(1'b0, pcm_in_pkg::COUNT_OFFSET, 32'h0, 4'h0, r, e);
      chk("count read only", 32'h0, r);
      apb(1'b0, 8'h0c, 32'h0, 4'h0, r, e);
      chk("unmapped error", 1, e);
      chk("unmapped data", 32'h0, r);
   endtask : reg_case
   task automatic slave_case(input logic [1:0] f, input int wi, input logic lin);
      logic [31:0] r;
      logic e;
      framing = pcm_in_pkg::framing_type'(f);
      word_len = lin ? pcm_in_pkg::WL_24 : wl_tab[wi];
      apb(1'b1, pcm_in_pkg::CTRL_OFFSET, ctrl(1'b1, 1'b0, f, lin ? 2'h3 : 2'(wi), lin, 1'b0), 4'h1, r, e);
      apb(1'b0, pcm_in_pkg::STATUS_OFFSET, 32'h0, 4'h0, r, e);
      chk("config error", lin, r[pcm_in_pkg::STATUS_CFG_ERR_BIT]);
      qd.delete();
      qr.delete();
      adc_model_i.run_halves(2, (f == 2'h0) ? 1'b0 : 1'b1);
      repeat (20) @(posedge clk);
      check_pair(lin ? 16 : int'(wl_tab[wi]));
      chk("last is right", 1, qr.size() > 0 && qr[$] === 1'b1);
      chk("bit clock input", 1, bit_clock_pin_oe_n);
      chk("channel clock input", 1, channel_select_clock_pin_oe_n);
      chk("master clock idle", 0, master_clock_out);
   endtask : slave_case
   task automatic master_case(input logic rt);
      logic [31:0] r;
      logic e;
      int n;
      framing = pcm_in_pkg::FRAMING_I2S;
      word_len = pcm_in_pkg::WL_24;
      apb(1'b1, pcm_in_pkg::CTRL_OFFSET, ctrl(1'b1, 1'b1, 2'h0, 2'h3, 1'b0, rt), 4'h1, r, e);
      repeat (50) @(posedge clk);
      chk("bit clock driven", 0, bit_clock_pin_oe_n);
      chk("channel clock driven", 0, channel_select_clock_pin_oe_n);
      gap(0, n);
      chk("master clock half", 4, n);
      gap(1, n);
      chk("bit clock half", rt ? 24 : 16, n);
      gap(2, n);
      chk("channel clock half", rt ? 1536 : 1024, n);
      qd.delete();
      qr.delete();
      repeat (7000) @(posedge clk);
      check_pair(24);
   endtask : master_case
   task automatic overrun_case();
      logic [31:0] r, c0, c1;
      logic e;
      // Stop the generated clocks before stalling the sink, so no stray edge lands a word.
      apb(1'b1, pcm_in_pkg::CTRL_OFFSET, 32'h0, 4'h1, r, e);
      repeat (10) @(posedge clk);
      sample_ready <= 1'b0;
      framing = pcm_in_pkg::FRAMING_LEFT;
      word_len = pcm_in_pkg::WL_16;
      apb(1'b1, pcm_in_pkg::CTRL_OFFSET, ctrl(1'b1, 1'b0, 2'h1, 2'h0, 1'b0, 1'b0), 4'h1, r, e);
      apb(1'b0, pcm_in_pkg::COUNT_OFFSET, 32'h0, 4'h0, c0, e);
      adc_model_i.run_halves(6, 1'b1);
      apb(1'b0, pcm_in_pkg::STATUS_OFFSET, 32'h0, 4'h0, r, e);
      chk("overrun set", 1, r[pcm_in_pkg::STATUS_OVERRUN_BIT]);
      chk("fifo level", 4, r[pcm_in_pkg::STATUS_LEVEL_LSB+:3]);
      apb(1'b1, pcm_in_pkg::STATUS_OFFSET, 32'h1, 4'h1, r, e);
      apb(1'b0, pcm_in_pkg::STATUS_OFFSET, 32'h0, 4'h0, r, e);
      chk("overrun cleared", 0, r[pcm_in_pkg::STATUS_OVERRUN_BIT]);
      apb(1'b0, pcm_in_pkg::COUNT_OFFSET, 32'h0, 4'h0, c1, e);
      chk("count delta", 4, c1 - c0);
      qd.delete();
      qr.delete();
      sample_ready <= 1'b1;
      repeat (10) @(posedge clk);
      chk("drained", 4, qd.size());
      chk("first kept", {8'h0, left_word & 24'hffff00}, qd.size() > 0 ? qd[0] : 24'h0);
   endtask : overrun_case
   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      chk("reset pins released", 2'h3, {bit_clock_pin_oe_n, channel_select_clock_pin_oe_n});
      chk("reset master clock", 0, master_clock_out);
      reg_case();
      for (int f = 0; f < 3; f++) begin
         for (int w = 0; w < 4; w++) begin
            slave_case(2'(f), w, 1'b0);
         end
      end
      slave_case(2'h0, 0, 1'b1);
      slave_case(2'h1, 0, 1'b1);
      master_case(1'b0);
      master_case(1'b1);
      overrun_case();
      end_sim();
   end
endmodule : pcm_audio_serial_input_test
`default_nettype wire
